//--- dual_slope_pwm_timer.sv
// Dual-slope PWM timer: phase correct and phase-and-frequency correct modes.
// Assumes a register master on the plain strobe port, one clock, synchronous reset.
// Operation
// - Codes 1, 2, 3, A, B select phase correct up/down counting.
// - Phase correct top is 0xFF, 0x1FF, 0x3FF, capture or compare A.
// - Counter holds top for one timer tick, then turns downward.
// - Output mode 2 clears on up match, sets on down; mode 3 inverts.
// - Channel value reaches the pin only when its direction bit is output.
// - Phase correct sets the overflow flag at bottom.
// - Phase correct loads compares at top; register-top flag sets then.
// - A channel flag sets on a timer tick when count equals its compare value.
// - With fixed top, compare writes zero bits above the resolution.
// - In output mode 2, phase correct compare at bottom gives low, at top gives high.
// - Mode B with channel A mode 1 toggles A on each match.
// - Codes 8 and 9 select frequency correct, top capture or compare A.
// - Frequency correct loads compares at bottom and sets overflow there.
// - Frequency correct register-top flag sets when count reaches top.
// - Mode 9 with channel A mode 1 toggles A on each match.
// - Timer tick divides the system clock by 1, 8, 64, 256 or 1024.
// - In output mode 2, frequency correct compare at bottom gives low, at top gives high.
// - Output mode zero leaves the pin to normal port operation.
// - The prescaled tick is an enable in the system clock domain.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

module dual_slope_pwm_timer #(
	parameter int PRE_W = `PRE_CNT_W
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [15:0] RDATA_O,
	input  wire logic [1:0]  PORT_VALUE_I,
	output logic      [1:0]  PIN_O,
	output logic      [1:0]  PIN_OE_N_O
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pwm_timer_pkg::word_t      count_value_reg;
	pwm_timer_pkg::word_t      compare_value_a;
	pwm_timer_pkg::word_t      compare_value_b;
	pwm_timer_pkg::word_t      buf_a_reg;
	pwm_timer_pkg::word_t      buf_b_reg;
	pwm_timer_pkg::word_t      capture_top_value;
	pwm_timer_pkg::word_t      top_value;
	pwm_timer_pkg::word_t      fixed_mask;
	pwm_timer_pkg::wgm_t       waveform_mode_sel;
	pwm_timer_pkg::com_t       channel_a_output_mode;
	pwm_timer_pkg::com_t       channel_b_output_mode;
	pwm_timer_pkg::dual_kind_e kind;
	logic [7:0]                control_reg;
	logic [2:0]                prescale_reg;
	logic [1:0]                pin_direction_bit;
	logic [3:0]                flags_reg;
	logic [3:0]                flag_set;
	logic [1:0]                channel_output;
	logic                      count_down_reg;
	logic                      tick;
	logic                      at_top;
	logic                      at_bottom;
	logic                      match_a;
	logic                      match_b;
	logic                      top_from_a;
	logic                      top_from_capt;
	logic                      load_now;
	logic                      match_dir;

	// Next level of one channel output on a compare match.
	function automatic logic chan_next(input logic cur, input pwm_timer_pkg::com_t mode,
		input logic down, input logic toggle_ok);
		case (mode)
			`COM_NONINV: chan_next = down;
			`COM_INV:    chan_next = !down;
			`COM_TOGGLE: chan_next = toggle_ok ? !cur : cur;
			default:     chan_next = cur;
		endcase
	endfunction : chan_next

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// The mode code is the low and high field pair read as one nibble.
	assign waveform_mode_sel     = control_reg[`CTL_WGM_LSB +: 4];
	assign channel_a_output_mode = control_reg[`CTL_COMA_LSB +: 2];
	assign channel_b_output_mode = control_reg[`CTL_COMB_LSB +: 2];

	// Classifies the mode and picks TOP.
	always_comb begin
		kind       = pwm_timer_pkg::SEL_NONE;
		top_value  = `TOP_8BIT;
		fixed_mask = 16'hFFFF;
		case (waveform_mode_sel)
			`WGM_PC8: begin
				kind       = pwm_timer_pkg::SEL_PC_FIXED;
				top_value  = `TOP_8BIT;
				fixed_mask = `TOP_8BIT;
			end
			`WGM_PC9: begin
				kind       = pwm_timer_pkg::SEL_PC_FIXED;
				top_value  = `TOP_9BIT;
				fixed_mask = `TOP_9BIT;
			end
			`WGM_PC10: begin
				kind       = pwm_timer_pkg::SEL_PC_FIXED;
				top_value  = `TOP_10BIT;
				fixed_mask = `TOP_10BIT;
			end
			`WGM_PC_CAPT: begin
				kind      = pwm_timer_pkg::SEL_PC_REG;
				top_value = capture_top_value;
			end
			`WGM_PC_CMPA: begin
				kind      = pwm_timer_pkg::SEL_PC_REG;
				top_value = compare_value_a;
			end
			`WGM_PFC_CAPT: begin
				kind      = pwm_timer_pkg::SEL_PFC;
				top_value = capture_top_value;
			end
			`WGM_PFC_CMPA: begin
				kind      = pwm_timer_pkg::SEL_PFC;
				top_value = compare_value_a;
			end
			default: begin
				kind = pwm_timer_pkg::SEL_NONE;
			end
		endcase
	end

	assign top_from_a    = (waveform_mode_sel == `WGM_PC_CMPA) ||
	                       (waveform_mode_sel == `WGM_PFC_CMPA);
	assign top_from_capt = (waveform_mode_sel == `WGM_PC_CAPT) ||
	                       (waveform_mode_sel == `WGM_PFC_CAPT);

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	pwm_prescaler #(
		.CNT_W (PRE_W)
	) u_prescaler (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (RST_N_I),
		.sel_i   (prescale_reg),
		.tick_o  (tick)
	);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	assign at_top    = (count_value_reg == top_value);
	assign at_bottom = (count_value_reg == `RST_WORD);
	assign match_a   = (count_value_reg == compare_value_a);
	assign match_b   = (count_value_reg == compare_value_b);
	assign load_now  = tick && (((kind != pwm_timer_pkg::SEL_PFC) && at_top) ||
	                            ((kind == pwm_timer_pkg::SEL_PFC) && at_bottom));

	// Up from bottom to top, one tick at top, then down to bottom.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			count_value_reg <= `RST_WORD;
			count_down_reg  <= 1'b0;
		end else if (WR_I && ADDR_I == `OFS_COUNT) begin
			count_value_reg <= WDATA_I;
		end else if (tick && kind != pwm_timer_pkg::SEL_NONE) begin
			if (!count_down_reg) begin
				if (at_top) begin
					count_down_reg  <= 1'b1;
					count_value_reg <= count_value_reg - 16'h0001;
				end else begin
					count_value_reg <= count_value_reg + 16'h0001;
				end
			end else if (at_bottom) begin
				count_down_reg  <= 1'b0;
				count_value_reg <= count_value_reg + 16'h0001;
			end else begin
				count_value_reg <= count_value_reg - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Compare buffers
	// ----------------------------------------------------------------
	// Writes land in the buffers; the active values load at top or bottom, or every cycle when no dual-slope mode is set.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			buf_a_reg       <= `RST_WORD;
			buf_b_reg       <= `RST_WORD;
			compare_value_a <= `RST_WORD;
			compare_value_b <= `RST_WORD;
		end else begin
			if (WR_I && ADDR_I == `OFS_COMPARE_A) begin
				buf_a_reg <= WDATA_I & fixed_mask;
			end
			if (WR_I && ADDR_I == `OFS_COMPARE_B) begin
				buf_b_reg <= WDATA_I & fixed_mask;
			end
			if (kind == pwm_timer_pkg::SEL_NONE) begin
				compare_value_a <= buf_a_reg;
				compare_value_b <= buf_b_reg;
			end else if (load_now) begin
				compare_value_a <= buf_a_reg;
				compare_value_b <= buf_b_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	// Hardware events; a set beats a write-one clear in the same cycle.
	always_comb begin
		flag_set = 4'h0;
		if (tick && kind != pwm_timer_pkg::SEL_NONE) begin
			flag_set[`FLG_OVF]  = at_bottom;
			flag_set[`FLG_CMPA] = match_a || (top_from_a && at_top);
			flag_set[`FLG_CMPB] = match_b;
			flag_set[`FLG_CAPT] = top_from_capt && at_top;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			flags_reg <= 4'h0;
		end else begin
			flags_reg <= (flags_reg & ~((WR_I && ADDR_I == `OFS_FLAGS) ? WDATA_I[3:0] : 4'h0))
			             | flag_set;
		end
	end

	// ----------------------------------------------------------------
	// Waveform outputs
	// ----------------------------------------------------------------
	// At top and bottom a match follows the direction the counter turns
	// to, so in output mode 2 a compare at bottom stays low and one at top stays high.
	assign match_dir = at_top ? 1'b1 : (at_bottom ? 1'b0 : count_down_reg);

	// Match while counting up or down drives the channel level.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			channel_output <= 2'h0;
		end else if (tick && kind != pwm_timer_pkg::SEL_NONE) begin
			if (match_a) begin
				channel_output[0] <= chan_next(channel_output[0], channel_a_output_mode,
					match_dir, top_from_a);
			end
			if (match_b) begin
				channel_output[1] <= chan_next(channel_output[1], channel_b_output_mode,
					match_dir, 1'b0);
			end
		end
	end

	// Pin mux: channel or port value, driven only when direction is output.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			PIN_O      <= 2'h0;
			PIN_OE_N_O <= 2'h3;
		end else begin
			PIN_O[0]   <= (channel_a_output_mode == `COM_OFF) ? PORT_VALUE_I[0]
			                                                : channel_output[0];
			PIN_O[1]   <= (channel_b_output_mode == `COM_OFF) ? PORT_VALUE_I[1]
			                                                : channel_output[1];
			PIN_OE_N_O <= ~pin_direction_bit;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// Configuration writes.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			control_reg       <= 8'h00;
			prescale_reg      <= `PRE_STOP;
			capture_top_value <= `RST_WORD;
			pin_direction_bit <= 2'h0;
		end else if (WR_I) begin
			case (ADDR_I)
				`OFS_CONTROL:     control_reg       <= WDATA_I[7:0];
				`OFS_PRESCALE:    prescale_reg      <= WDATA_I[2:0];
				`OFS_CAPTURE_TOP: capture_top_value <= WDATA_I;
				`OFS_DIRECTION:   pin_direction_bit <= WDATA_I[1:0];
				default:          control_reg       <= control_reg;
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			RDATA_O <= `RST_WORD;
		end else if (RD_I) begin
			case (ADDR_I)
				`OFS_CONTROL:     RDATA_O <= {8'h00, control_reg};
				`OFS_PRESCALE:    RDATA_O <= {13'h0000, prescale_reg};
				`OFS_COMPARE_A:   RDATA_O <= compare_value_a;
				`OFS_COMPARE_B:   RDATA_O <= compare_value_b;
				`OFS_CAPTURE_TOP: RDATA_O <= capture_top_value;
				`OFS_COUNT:       RDATA_O <= count_value_reg;
				`OFS_FLAGS:       RDATA_O <= {12'h000, flags_reg};
				`OFS_DIRECTION:   RDATA_O <= {14'h0000, pin_direction_bit};
				default:          RDATA_O <= `RST_WORD;
			endcase
		end else begin
			RDATA_O <= `RST_WORD;
		end
	end

endmodule : dual_slope_pwm_timer

//--- pwm_prescaler.sv
// Prescaler producing the one-cycle timer clock enable.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

module pwm_prescaler #(
	parameter int CNT_W = `PRE_CNT_W
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);

	logic [CNT_W-1:0] div_reg;
	logic             tick_next;

	// Free-running divider of the system clock.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Selects the divide factor; the tick is an enable, not a clock.
	always_comb begin
		case (sel_i)
			`PRE_DIV1:    tick_next = 1'b1;
			`PRE_DIV8:    tick_next = (div_reg[2:0] == 3'h7);
			`PRE_DIV64:   tick_next = (div_reg[5:0] == 6'h3F);
			`PRE_DIV256:  tick_next = (div_reg[7:0] == 8'hFF);
			`PRE_DIV1024: tick_next = (div_reg[9:0] == 10'h3FF);
			default:      tick_next = 1'b0;
		endcase
	end

	assign tick_o = tick_next;

endmodule : pwm_prescaler

//--- pwm_timer_consts.svh
// Constants for the dual-slope PWM timer: register offsets, fields, modes and reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL     4'h0
`define OFS_PRESCALE    4'h1
`define OFS_COMPARE_A   4'h2
`define OFS_COMPARE_B   4'h3
`define OFS_CAPTURE_TOP 4'h4
`define OFS_COUNT       4'h5
`define OFS_FLAGS       4'h6
`define OFS_DIRECTION   4'h7

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTL_WGM_LSB     0
`define CTL_COMA_LSB    4
`define CTL_COMB_LSB    6

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define FLG_OVF         0
`define FLG_CMPA        1
`define FLG_CMPB        2
`define FLG_CAPT        3

// ----------------------------------------------------------------
// Waveform mode codes and fixed tops
// ----------------------------------------------------------------
`define WGM_PC8         4'h1
`define WGM_PC9         4'h2
`define WGM_PC10        4'h3
`define WGM_PFC_CAPT    4'h8
`define WGM_PFC_CMPA    4'h9
`define WGM_PC_CAPT     4'hA
`define WGM_PC_CMPA     4'hB
`define TOP_8BIT        16'h00FF
`define TOP_9BIT        16'h01FF
`define TOP_10BIT       16'h03FF

// ----------------------------------------------------------------
// Compare-output modes
// ----------------------------------------------------------------
`define COM_OFF         2'h0
`define COM_TOGGLE      2'h1
`define COM_NONINV      2'h2
`define COM_INV         2'h3

// ----------------------------------------------------------------
// Prescaler selections, divider width and reset values
// ----------------------------------------------------------------
`define PRE_STOP        3'h0
`define PRE_DIV1        3'h1
`define PRE_DIV8        3'h2
`define PRE_DIV64       3'h3
`define PRE_DIV256      3'h4
`define PRE_DIV1024     3'h5
`define RST_WORD        16'h0000
`define PRE_CNT_W       10

`endif

//--- pwm_timer_monitor.sv
// Port-level checker for the dual-slope PWM timer.
// Assumes a bind onto the top module; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

module pwm_timer_monitor (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_N_I,
	input wire logic [3:0]  ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic [1:0]  PORT_VALUE_I,
	input wire logic [1:0]  PIN_O,
	input wire logic [1:0]  PIN_OE_N_O
);
	// ----------------------------------------------------------------
	// Shadow state
	// ----------------------------------------------------------------
	logic [7:0] ctl_reg;
	logic [2:0] pre_reg;

	// Mirrors control and prescale writes so the pin checks know the mode.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			ctl_reg <= 8'h00;
			pre_reg <= 3'h0;
		end else if (WR_I && ADDR_I == `OFS_CONTROL) begin
			ctl_reg <= WDATA_I[7:0];
		end else if (WR_I && ADDR_I == `OFS_PRESCALE) begin
			pre_reg <= WDATA_I[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	chk_reset_outputs: assert property (disable iff (1'b0) !RST_N_I |=>
		RDATA_O == 16'h0000 && PIN_O == 2'h0 && PIN_OE_N_O == 2'h3)
		else $error("outputs not cleared by reset");
	chk_read_window: assert property (!RD_I |=> RDATA_O == 16'h0000)
		else $error("read data outside its cycle");
	chk_unmapped_read: assert property (RD_I && ADDR_I > 4'h7 |=> RDATA_O == 16'h0000)
		else $error("unmapped read not zero");
	chk_dir_enable: assert property (WR_I && ADDR_I == `OFS_DIRECTION |=>
		##1 PIN_OE_N_O == ~$past(WDATA_I[1:0], 2))
		else $error("enable does not follow direction write");
	chk_dir_hold: assert property (!(WR_I && ADDR_I == `OFS_DIRECTION) &&
		!$past(WR_I && ADDR_I == `OFS_DIRECTION) |=> $stable(PIN_OE_N_O))
		else $error("enable moved without a write");
	chk_dir_readback: assert property (RD_I && ADDR_I == `OFS_DIRECTION |=>
		RDATA_O[1:0] == ~PIN_OE_N_O)
		else $error("direction readback differs from enable");
	chk_port_pass_a: assert property (ctl_reg[5:4] == 2'h0 |=>
		PIN_O[0] == $past(PORT_VALUE_I[0]))
		else $error("pin A not following port level");
	chk_port_pass_b: assert property (ctl_reg[7:6] == 2'h0 |=>
		PIN_O[1] == $past(PORT_VALUE_I[1]))
		else $error("pin B not following port level");
	chk_stopped_hold: assert property (pre_reg == 3'h0 && $past(pre_reg) == 3'h0 &&
		ctl_reg[5:4] != 2'h0 && $past(ctl_reg[5:4]) != 2'h0 |=> $stable(PIN_O[0]))
		else $error("pin A moved with the prescaler stopped");

endmodule : pwm_timer_monitor

//--- pwm_timer_pkg.sv
// Types shared by the dual-slope PWM timer modules.
// Assumes the constants header sits in the same folder.
`include "pwm_timer_consts.svh"

package pwm_timer_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [15:0] word_t;
	typedef logic [3:0]  wgm_t;
	typedef logic [1:0]  com_t;
	typedef enum logic [1:0] {
		SEL_PC_FIXED,
		SEL_PC_REG,
		SEL_PFC,
		SEL_NONE
	} dual_kind_e;

endpackage : pwm_timer_pkg

//--- test_dual_slope_pwm_timer.sv
// Self-checking bench for the dual-slope PWM timer.
// Assumes the design, its package and the port monitor are compiled first.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

module test_dual_slope_pwm_timer;
	// ----------------------------------------------------------------
	// Signals and tables
	// ----------------------------------------------------------------
	logic        clk_sys    = 1'b0;
	logic        rst_n      = 1'b0;
	logic [3:0]  addr       = 4'h0;
	logic [15:0] wdata      = 16'h0000;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic [1:0]  port_value = 2'h0;
	logic [15:0] rdata;
	logic [1:0]  pin;
	logic [1:0]  pin_oe_n;
	logic        rd_d       = 1'b0;
	logic [15:0] exp_q[$];
	logic [15:0] top;
	int          h;
	int          error_cnt    = 0;
	int          total_checks = 0;
	logic [1:0]  com_b[6] = '{`COM_NONINV, `COM_INV, `COM_NONINV, `COM_INV, `COM_NONINV, `COM_INV};
	logic [15:0] cmp_b[6] = '{16'h0002, 16'h0002, 16'h0000, 16'h0000, 16'h0005, 16'h0005};
	logic [15:0] hi_b[6]  = '{16'h0008, 16'h000C, 16'h0000, 16'h0014, 16'h0014, 16'h0000};
	logic [3:0]  modes[7] = '{`WGM_PC8, `WGM_PC9, `WGM_PC10, `WGM_PC_CAPT, `WGM_PC_CMPA,
		`WGM_PFC_CAPT, `WGM_PFC_CMPA};
	int          divs[5]  = '{1, 8, 64, 256, 1024};

	// Free-running 40 MHz clock.
	always #12.5 clk_sys = ~clk_sys;

	dual_slope_pwm_timer dut (
		.CLK_SYS_I    (clk_sys),
		.RST_N_I      (rst_n),
		.ADDR_I       (addr),
		.WDATA_I      (wdata),
		.WR_I         (wr),
		.RD_I         (rd),
		.RDATA_O      (rdata),
		.PORT_VALUE_I (port_value),
		.PIN_O        (pin),
		.PIN_OE_N_O   (pin_oe_n)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// Bus cycles start just after a rising edge; each strobe drops in idle or when the other strobe is raised.
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk_sys);
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, input logic [15:0] want);
		exp_q.push_back(want);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask : rd_reg

	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask : idle

	// Counts cycles with the chosen pin high, sampling away from the edge.
	task automatic highs(input int n, input int b);
		h = 0;
		repeat (n) begin
			@(negedge clk_sys);
			if (pin[b] === 1'b1) h++;
		end
		@(posedge clk_sys);
	endtask : highs

	// Read data stand one cycle after the strobe; match them to the oldest note.
	always @(posedge clk_sys) begin
		rd_d <= rd;
		if (rd_d && exp_q.size() > 0) begin
			check(rdata, exp_q.pop_front());
		end
	end

	// Cuts a hang short.
	initial begin
		repeat (95000) @(posedge clk_sys);
		error_cnt++;
		$display("unexpected at %0t: run did not finish", $time);
		end_sim();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(4415));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		wr_reg(4'h9, 16'hFFFF);
		for (int a = 0; a < 10; a++) begin
			rd_reg(4'(a), 16'h0000);
		end
		idle(2);
		$display("reset test done");
		wr_reg(`OFS_DIRECTION, 16'h0003);
		rd_reg(`OFS_DIRECTION, 16'h0003);
		for (int i = 0; i < 8; i++) begin
			port_value <= 2'($urandom());
			idle(2);
			check({14'h0000, pin}, {14'h0000, port_value});
		end
		check({14'h0000, pin_oe_n}, 16'h0000);
		wr_reg(`OFS_DIRECTION, 16'h0000);
		idle(2);
		check({14'h0000, pin_oe_n}, 16'h0003);
		top = 16'($urandom());
		wr_reg(`OFS_COUNT, top);
		rd_reg(`OFS_COUNT, top);
		idle(2);
		$display("port test done");
		// Each dual-slope mode runs past top and bottom, then its flags are read.
		foreach (modes[i]) begin
			top = (modes[i] == `WGM_PC8) ? `TOP_8BIT : (modes[i] == `WGM_PC9) ? `TOP_9BIT :
				(modes[i] == `WGM_PC10) ? `TOP_10BIT : 16'h0005;
			wr_reg(`OFS_PRESCALE, {13'h0000, `PRE_STOP});
			wr_reg(`OFS_CONTROL, 16'h0000);
			wr_reg(`OFS_COMPARE_A, 16'h0005);
			wr_reg(`OFS_CAPTURE_TOP, 16'h0005);
			wr_reg(`OFS_COUNT, 16'h0000);
			wr_reg(`OFS_CONTROL, {8'h00, `COM_NONINV, `COM_NONINV, modes[i]});
			wr_reg(`OFS_COMPARE_B, (top == 16'h0005) ? 16'h0002 : 16'hFFFF);
			wr_reg(`OFS_FLAGS, 16'h000F);
			wr_reg(`OFS_PRESCALE, {13'h0000, `PRE_DIV1});
			idle(2 * top + 8);
			wr_reg(`OFS_PRESCALE, {13'h0000, `PRE_STOP});
			rd_reg(`OFS_FLAGS, (modes[i] == `WGM_PC_CAPT || modes[i] == `WGM_PFC_CAPT) ?
				16'h000F : 16'h0007);
			rd_reg(`OFS_COMPARE_B, (top == 16'h0005) ? 16'h0002 : top);
			idle(2);
		end
		$display("flag test done");
		// Duty of both channels in the compare-A-top modes B and 9, top at five.
		wr_reg(`OFS_DIRECTION, 16'h0003);
		wr_reg(`OFS_PRESCALE, {13'h0000, `PRE_DIV1});
		for (int j = 0; j < 2; j++) begin
			for (int k = 0; k < 6; k++) begin
				wr_reg(`OFS_CONTROL, {8'h00, com_b[k], `COM_TOGGLE,
					(j == 1) ? `WGM_PFC_CMPA : `WGM_PC_CMPA});
				wr_reg(`OFS_COMPARE_B, cmp_b[k]);
				idle(30);
				highs(20, 1);
				check(16'(h), hi_b[k]);
				highs(20, 0);
				check(16'(h), 16'h000A);
			end
		end
		$display("duty test done");
		foreach (divs[i]) begin
			wr_reg(`OFS_PRESCALE, 16'(i + 1));
			idle(20 * divs[i]);
			highs(20 * divs[i], 0);
			check(16'(h), 16'(10 * divs[i]));
		end
		$display("prescale test done");
		// Back-to-back count reads trace the triangle from bottom.
		wr_reg(`OFS_PRESCALE, {13'h0000, `PRE_DIV1});
		idle(4);
		wr_reg(`OFS_COUNT, 16'h0000);
		for (int k = 0; k < 14; k++) begin
			rd_reg(`OFS_COUNT, (k % 10 <= 5) ? 16'(k % 10) : 16'(10 - k % 10));
		end
		idle(2);
		$display("count test done");
		rst_n <= 1'b0;
		idle(2);
		check({14'h0000, pin_oe_n}, 16'h0003);
		rst_n <= 1'b1;
		rd_reg(`OFS_COUNT, 16'h0000);
		rd_reg(`OFS_FLAGS, 16'h0000);
		idle(3);
		if (exp_q.size() != 0) begin
			error_cnt++;
			$display("unexpected at %0t: reads left unanswered", $time);
		end
		$display("second reset test done");
		end_sim();
	end

endmodule : test_dual_slope_pwm_timer

bind dual_slope_pwm_timer pwm_timer_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.PORT_VALUE_I(PORT_VALUE_I), .PIN_O(PIN_O), .PIN_OE_N_O(PIN_OE_N_O));
